// [rtl/data_store.sv]
// Byte-wide data memory with one write port and a registered read port
`timescale 1ns/1ps
module data_store
    import ext_alu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rd_en,
    input wire logic [MEM_ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [MEM_ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);

    logic [DATA_W-1:0] cells [MEM_DEPTH];

    // Flat array: every address is reachable, no bank select exists
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    // Read data held in a register; a same-edge write is not bypassed
    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end

endmodule

// [rtl/ext_alu_pkg.sv]
// Constants, opcodes, states and shared helpers for the extended memory operand ALU
package ext_alu_pkg;

    localparam int DATA_W = 8;
    localparam int MEM_ADDR_W = 11;
    localparam int MEM_DEPTH = 2048;

    // Values after reset
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic READY_RESET = 1'b1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Decimal adjust figures
    localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;
    localparam logic [3:0] BCD_NIBBLE_FIX = 4'h6;
    localparam logic [3:0] BCD_NIBBLE_NONE = 4'h0;

    // Operation codes, numbered from 0 in this order
    typedef enum logic [4:0] {
        op_invert_mem,
        op_invert_to_working,
        op_bcd_adjust_to_mem,
        op_mem_decrement,
        op_decrement_to_working,
        op_mem_increment,
        op_increment_to_working,
        op_mem_move_load,
        op_mem_move_store,
        op_or_to_working,
        op_or_into_mem,
        op_rotate_left_mem,
        op_rotate_left_to_working,
        op_rotate_left_thru_carry_mem,
        op_rotate_left_thru_carry_to_working,
        op_rotate_right_mem,
        op_rotate_right_to_working,
        op_rotate_right_thru_carry_mem,
        op_rotate_right_thru_carry_to_working,
        op_subtract_borrow_to_working,
        op_subtract_borrow_into_mem
    } op_t;

    typedef enum logic [0:0] {
        st_idle,
        st_exec
    } state_t;

    // Zero test shared by every Z-updating operation
    function automatic logic byte_is_zero(input logic [7:0] value);
        return value == BYTE_ZERO;
    endfunction

endpackage

// [rtl/extended_memory_operand_alu.sv]
// Execution datapath for the extended memory operand instructions
`timescale 1ns/1ps
module extended_memory_operand_alu
    import ext_alu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire op_t op_code,
    input wire logic [MEM_ADDR_W-1:0] op_addr,
    output logic op_ready,
    output logic op_done,
    output logic op_illegal,
    input wire logic acc_load_en,
    input wire logic [7:0] acc_load_data,
    input wire logic flag_load_en,
    input wire logic [5:0] flag_load_data,
    output logic [7:0] working_register,
    output logic zero_flag,
    output logic carry_flag,
    output logic nibble_carry_flag,
    output logic signed_range_exceeded_flag,
    output logic signed_result_flag,
    output logic chained_zero_flag,
    input wire logic host_wr_en,
    input wire logic host_rd_en,
    input wire logic [MEM_ADDR_W-1:0] host_addr,
    input wire logic [7:0] host_wr_data,
    output logic [7:0] host_rd_data,
    output logic host_rd_valid
);

    state_t state;
    op_t cur_op;
    logic [MEM_ADDR_W-1:0] cur_addr;

    logic accept;
    logic idle_now;
    logic host_rd_go;
    logic host_rd_pending;

    logic [7:0] mem_q;
    logic mem_rd_en;
    logic [MEM_ADDR_W-1:0] mem_rd_addr;
    logic mem_wr_en;
    logic [MEM_ADDR_W-1:0] mem_wr_addr;
    logic [7:0] mem_wr_data;

    logic [7:0] result;
    logic exec_wr;
    logic op_legal;
    logic fix_low;
    logic fix_high;

    logic [7:0] next_acc;
    logic next_z;
    logic next_c;
    logic next_ac;
    logic next_ov;
    logic next_sc;
    logic next_cz;

    logic [7:0] sbc_diff;
    logic sbc_c;
    logic sbc_ac;
    logic sbc_ov;
    logic sbc_z;
    logic sbc_sc;
    logic sbc_cz;

    // Handshake: one operation at a time, taken only while idle
    assign idle_now = (state == st_idle);
    assign accept = op_valid & op_ready & idle_now;
    // Host reads share the read port and lose to an operation fetch
    assign host_rd_go = host_rd_en & idle_now & ~accept;

    // Read port: operand fetch uses the full address, no bank register
    always_comb begin
        mem_rd_en = accept | host_rd_go;
        mem_rd_addr = accept ? op_addr : host_addr;
    end

    // Write port: result write-back wins; host writes only while idle
    always_comb begin
        mem_wr_en = 1'b0;
        mem_wr_addr = host_addr;
        mem_wr_data = host_wr_data;
        if (state == st_exec) begin
            mem_wr_en = exec_wr;
            mem_wr_addr = cur_addr;
            mem_wr_data = result;
        end else if (host_wr_en) begin
            mem_wr_en = 1'b1;
        end
    end

    data_store u_data_store (
        .sys_clk(sys_clk),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_q),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data)
    );

    sub_borrow_unit u_sub_borrow_unit (
        .minuend(working_register),
        .subtrahend(mem_q),
        .carry_in(carry_flag),
        .cz_in(chained_zero_flag),
        .diff(sbc_diff),
        .c_out(sbc_c),
        .ac_out(sbc_ac),
        .ov_out(sbc_ov),
        .z_out(sbc_z),
        .sc_out(sbc_sc),
        .cz_out(sbc_cz)
    );

    // Sequencer: fetch on accept, execute on the next edge, then idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (accept) begin
                        state <= st_exec;
                    end
                end
                st_exec: begin
                    state <= st_idle;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Operation and address held for the execute cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_op <= op_invert_mem;
            cur_addr <= '0;
        end else if (accept) begin
            cur_op <= op_code;
            cur_addr <= op_addr;
        end
    end

    // Ready drops for the execute cycle so a second request waits
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_ready <= READY_RESET;
        end else if (accept) begin
            op_ready <= 1'b0;
        end else if (state == st_exec) begin
            op_ready <= 1'b1;
        end
    end

    // Completion and illegal-code pulses, one cycle each
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_done <= 1'b0;
            op_illegal <= 1'b0;
        end else begin
            op_done <= (state == st_exec);
            op_illegal <= (state == st_exec) & ~op_legal;
        end
    end

    // Decimal adjust conditions on the working byte and flags
    always_comb begin
        fix_low = (working_register[3:0] > BCD_NIBBLE_MAX) | nibble_carry_flag;
        fix_high = (working_register[7:4] > BCD_NIBBLE_MAX) | carry_flag;
    end

    // Operation decode: result, destination and flag effects
    always_comb begin
        next_acc = working_register;
        next_z = zero_flag;
        next_c = carry_flag;
        next_ac = nibble_carry_flag;
        next_ov = signed_range_exceeded_flag;
        next_sc = signed_result_flag;
        next_cz = chained_zero_flag;
        result = mem_q;
        exec_wr = 1'b0;
        op_legal = 1'b1;
        case (cur_op)
            op_invert_mem: begin
                result = ~mem_q;
                exec_wr = 1'b1;
                next_z = byte_is_zero(result);
            end
            op_invert_to_working: begin
                result = ~mem_q;
                next_acc = result;
                next_z = byte_is_zero(result);
            end
            op_bcd_adjust_to_mem: begin
                // Each nibble gets its own +6; low carry ripples into high
                result = working_register + {fix_high ? BCD_NIBBLE_FIX : BCD_NIBBLE_NONE,
                    fix_low ? BCD_NIBBLE_FIX : BCD_NIBBLE_NONE};
                exec_wr = 1'b1;
                next_c = fix_high;
            end
            op_mem_decrement: begin
                result = mem_q - 8'h01;
                exec_wr = 1'b1;
                next_z = byte_is_zero(result);
            end
            op_decrement_to_working: begin
                result = mem_q - 8'h01;
                next_acc = result;
                next_z = byte_is_zero(result);
            end
            op_mem_increment: begin
                result = mem_q + 8'h01;
                exec_wr = 1'b1;
                next_z = byte_is_zero(result);
            end
            op_increment_to_working: begin
                result = mem_q + 8'h01;
                next_acc = result;
                next_z = byte_is_zero(result);
            end
            op_mem_move_load: begin
                next_acc = mem_q;
            end
            op_mem_move_store: begin
                result = working_register;
                exec_wr = 1'b1;
            end
            op_or_to_working: begin
                result = working_register | mem_q;
                next_acc = result;
                next_z = byte_is_zero(result);
            end
            op_or_into_mem: begin
                result = working_register | mem_q;
                exec_wr = 1'b1;
                next_z = byte_is_zero(result);
            end
            op_rotate_left_mem: begin
                result = {mem_q[6:0], mem_q[7]};
                exec_wr = 1'b1;
            end
            op_rotate_left_to_working: begin
                result = {mem_q[6:0], mem_q[7]};
                next_acc = result;
            end
            op_rotate_left_thru_carry_mem: begin
                result = {mem_q[6:0], carry_flag};
                exec_wr = 1'b1;
                next_c = mem_q[7];
            end
            op_rotate_left_thru_carry_to_working: begin
                result = {mem_q[6:0], carry_flag};
                next_acc = result;
                next_c = mem_q[7];
            end
            op_rotate_right_mem: begin
                result = {mem_q[0], mem_q[7:1]};
                exec_wr = 1'b1;
            end
            op_rotate_right_to_working: begin
                result = {mem_q[0], mem_q[7:1]};
                next_acc = result;
            end
            op_rotate_right_thru_carry_mem: begin
                result = {carry_flag, mem_q[7:1]};
                exec_wr = 1'b1;
                next_c = mem_q[0];
            end
            op_rotate_right_thru_carry_to_working: begin
                result = {carry_flag, mem_q[7:1]};
                next_acc = result;
                next_c = mem_q[0];
            end
            op_subtract_borrow_to_working, op_subtract_borrow_into_mem: begin
                result = sbc_diff;
                next_z = sbc_z;
                next_c = sbc_c;
                next_ac = sbc_ac;
                next_ov = sbc_ov;
                next_sc = sbc_sc;
                next_cz = sbc_cz;
                if (cur_op == op_subtract_borrow_into_mem) begin
                    exec_wr = 1'b1;
                end else begin
                    next_acc = sbc_diff;
                end
            end
            default: begin
                // Unassigned codes complete but change nothing
                op_legal = 1'b0;
            end
        endcase
    end

    // Working register: execute result, else a load while idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            working_register <= ACC_RESET;
        end else if (state == st_exec) begin
            working_register <= next_acc;
        end else if (acc_load_en) begin
            working_register <= acc_load_data;
        end
    end

    // Status flags: execute effects, else a load while idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_flag <= FLAG_RESET;
            carry_flag <= FLAG_RESET;
            nibble_carry_flag <= FLAG_RESET;
            signed_range_exceeded_flag <= FLAG_RESET;
            signed_result_flag <= FLAG_RESET;
            chained_zero_flag <= FLAG_RESET;
        end else if (state == st_exec) begin
            zero_flag <= next_z;
            carry_flag <= next_c;
            nibble_carry_flag <= next_ac;
            signed_range_exceeded_flag <= next_ov;
            signed_result_flag <= next_sc;
            chained_zero_flag <= next_cz;
        end else if (flag_load_en) begin
            zero_flag <= flag_load_data[0];
            carry_flag <= flag_load_data[1];
            nibble_carry_flag <= flag_load_data[2];
            signed_range_exceeded_flag <= flag_load_data[3];
            signed_result_flag <= flag_load_data[4];
            chained_zero_flag <= flag_load_data[5];
        end
    end

    // Host read: memory answers one edge later, captured one edge after that
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_rd_pending <= 1'b0;
            host_rd_valid <= 1'b0;
            host_rd_data <= BYTE_ZERO;
        end else begin
            host_rd_pending <= host_rd_go;
            host_rd_valid <= host_rd_pending;
            if (host_rd_pending) begin
                host_rd_data <= mem_q;
            end
        end
    end

endmodule

// [rtl/sub_borrow_unit.sv]
// Subtract-with-borrow arithmetic and its six status results
`timescale 1ns/1ps
module sub_borrow_unit
    import ext_alu_pkg::*;
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic carry_in,
    input wire logic cz_in,
    output logic [7:0] diff,
    output logic c_out,
    output logic ac_out,
    output logic ov_out,
    output logic z_out,
    output logic sc_out,
    output logic cz_out
);

    logic [8:0] wide;
    logic [4:0] low;

    // Borrow in is the inverted carry; bit 8 / bit 4 catch the borrow out
    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carry_in};
        low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, ~carry_in};
        diff = wide[7:0];
        c_out = ~wide[8];
        ac_out = ~low[4];
        ov_out = (minuend[7] ^ subtrahend[7]) & (wide[7] ^ minuend[7]);
        z_out = byte_is_zero(wide[7:0]);
        sc_out = ov_out ^ wide[7];
        // Chained zero keeps a multi-byte compare zero only if all bytes were
        cz_out = z_out & cz_in;
    end

endmodule

// [verification/ext_alu_assertions.sv]
// Port-level assertions for the extended memory operand ALU
`timescale 1ns/1ps
module ext_alu_assertions
    import ext_alu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire op_t op_code,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic acc_load_en,
    input wire logic flag_load_en,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic nibble_carry_flag,
    input wire logic signed_range_exceeded_flag,
    input wire logic signed_result_flag,
    input wire logic chained_zero_flag,
    input wire logic host_rd_en,
    input wire logic host_rd_valid
);
    logic take;
    logic [4:0] upper;
    logic [4:0] keep;
    logic [5:0] all6;
    // Clean accept only: a load at the same edge would change the operands
    assign take = op_valid && op_ready && !acc_load_en && !flag_load_en;
    // Flag groups that the various operations must leave alone
    assign upper = {chained_zero_flag, signed_result_flag, signed_range_exceeded_flag,
        nibble_carry_flag, carry_flag};
    assign keep = {upper[4:1], zero_flag};
    assign all6 = {upper, zero_flag};
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Execute cycle, then the completion pulse
    sequence s_exec;
        !op_ready ##1 op_done;
    endsequence
    // Results land at the second edge after the accept
    sequence s_result;
        ##1 op_done;
    endsequence
    chk_exec_timing:
        assert property (op_valid && op_ready |=> s_exec) else $error("late completion");
    chk_done_pulse:
        assert property (op_done |=> !op_done) else $error("done held too long");
    chk_acc_hold:
        assert property (op_ready && !acc_load_en |=> $stable(working_register))
        else $error("accumulator changed while idle");
    chk_no_flag_ops:
        assert property (take && op_code inside {op_mem_move_load, op_mem_move_store,
            op_rotate_left_mem, op_rotate_left_to_working, op_rotate_right_mem,
            op_rotate_right_to_working} |=> $stable(all6) ##1 $stable(all6))
        else $error("flag changed by a flagless op");
    chk_z_only_ops:
        assert property (take && op_code inside {[op_invert_mem:op_invert_to_working],
            [op_mem_decrement:op_increment_to_working], op_or_to_working, op_or_into_mem}
            |=> $stable(upper) ##1 $stable(upper)) else $error("flag beside Z changed");
    chk_bcd_flags:
        assert property (take && op_code == op_bcd_adjust_to_mem
            |=> $stable(keep) ##1 $stable(keep)) else $error("adjust changed a flag");
    chk_bcd_carry:
        assert property (take && op_code == op_bcd_adjust_to_mem && carry_flag
            |=> ##1 carry_flag) else $error("adjust cleared carry");
    chk_zero_result:
        assert property (take && op_code inside {op_invert_to_working, op_or_to_working,
            op_decrement_to_working, op_increment_to_working, op_subtract_borrow_to_working}
            |=> s_result ##0 (zero_flag == (working_register == 8'h00)))
        else $error("zero flag mismatch");
    chk_or_keeps_bits:
        assert property (take && op_code == op_or_to_working
            |=> ##1 ((~working_register & $past(working_register, 2)) == 8'h00))
        else $error("or lost a bit");
    chk_rlc_carry_in:
        assert property (take && op_code == op_rotate_left_thru_carry_to_working
            |=> ##1 (working_register[0] == $past(carry_flag, 2)))
        else $error("old carry not in bit 0");
    chk_rrc_carry_in:
        assert property (take && op_code == op_rotate_right_thru_carry_to_working
            |=> ##1 (working_register[7] == $past(carry_flag, 2)))
        else $error("old carry not in bit 7");
    chk_host_read:
        assert property (host_rd_en && op_ready && !op_valid |=> ##1 host_rd_valid)
        else $error("read answer missing");
endmodule

// [verification/tb.sv]
// Self-checking bench for the extended memory operand ALU
`timescale 1ns/1ps
module tb;
    import ext_alu_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic op_valid = 1'b0;
    op_t op_code = op_invert_mem;
    logic [10:0] op_addr = 11'h000;
    logic acc_load_en = 1'b0;
    logic [7:0] acc_load_data = 8'h00;
    logic flag_load_en = 1'b0;
    logic [5:0] flag_load_data = 6'h00;
    logic host_wr_en = 1'b0;
    logic host_rd_en = 1'b0;
    logic [10:0] host_addr = 11'h000;
    logic [7:0] host_wr_data = 8'h00;
    logic op_ready, op_done, op_illegal, host_rd_valid;
    logic zero_flag, carry_flag, nibble_carry_flag;
    logic signed_range_exceeded_flag, signed_result_flag, chained_zero_flag;
    logic [7:0] working_register;
    logic [7:0] host_rd_data;
    logic [5:0] flags;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Flags in the same order as the load port
    assign flags = {chained_zero_flag, signed_result_flag, signed_range_exceeded_flag,
        nibble_carry_flag, carry_flag, zero_flag};
    always #2 sys_clk = ~sys_clk;
    extended_memory_operand_alu i_extended_memory_operand_alu (.sys_clk(sys_clk),
        .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
        .op_ready(op_ready), .op_done(op_done), .op_illegal(op_illegal),
        .acc_load_en(acc_load_en), .acc_load_data(acc_load_data),
        .flag_load_en(flag_load_en), .flag_load_data(flag_load_data),
        .working_register(working_register), .zero_flag(zero_flag), .carry_flag(carry_flag),
        .nibble_carry_flag(nibble_carry_flag),
        .signed_range_exceeded_flag(signed_range_exceeded_flag),
        .signed_result_flag(signed_result_flag), .chained_zero_flag(chained_zero_flag),
        .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_addr(host_addr),
        .host_wr_data(host_wr_data), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid));
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One operation; waits a bounded time for the completion pulse
    task automatic do_op(input op_t code, input logic [10:0] addr);
        int n;
        op_valid = 1'b1;
        op_code = code;
        op_addr = addr;
        tick();
        op_valid = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chk({7'h00, op_done}, 8'h01);
        chk({7'h00, op_illegal}, {7'h00, code > op_subtract_borrow_into_mem});
    endtask
    task automatic mem_rd(input logic [10:0] addr, output logic [7:0] data);
        int n;
        host_rd_en = 1'b1;
        host_addr = addr;
        tick();
        host_rd_en = 1'b0;
        n = 0;
        while (host_rd_valid !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chk({7'h00, host_rd_valid}, 8'h01);
        data = host_rd_data;
    endtask
    // Preload byte, accumulator and flags in one idle cycle, run, judge all three
    task automatic run(input op_t code, input logic [10:0] addr, input logic [7:0] m,
        input logic [7:0] a, input logic [5:0] f, input logic [7:0] em,
        input logic [7:0] ea, input logic [5:0] ef);
        logic [7:0] got;
        host_wr_en = 1'b1;
        host_addr = addr;
        host_wr_data = m;
        acc_load_en = 1'b1;
        acc_load_data = a;
        flag_load_en = 1'b1;
        flag_load_data = f;
        tick();
        host_wr_en = 1'b0;
        acc_load_en = 1'b0;
        flag_load_en = 1'b0;
        do_op(code, addr);
        chk(working_register, ea);
        chk({2'b00, flags}, {2'b00, ef});
        mem_rd(addr, got);
        chk(got, em);
    endtask
    task automatic t_reset_state();
        chk({7'h00, op_ready}, 8'h01);
        chk(working_register, 8'h00);
        chk({2'b00, flags}, 8'h00);
    endtask
    task automatic t_invert_step();
        run(op_invert_mem, 11'h7ff, 8'hff, 8'h11, 6'h3e, 8'h00, 8'h11, 6'h3f);
        run(op_invert_to_working, 11'h000, 8'h5a, 8'h00, 6'h3f, 8'h5a, 8'ha5, 6'h3e);
        run(op_mem_increment, 11'h401, 8'hff, 8'h22, 6'h00, 8'h00, 8'h22, 6'h01);
        run(op_increment_to_working, 11'h402, 8'h7f, 8'h22, 6'h01, 8'h7f, 8'h80, 6'h00);
        run(op_mem_decrement, 11'h403, 8'h01, 8'h22, 6'h3e, 8'h00, 8'h22, 6'h3f);
        run(op_decrement_to_working, 11'h404, 8'h00, 8'h22, 6'h3f, 8'h00, 8'hff, 6'h3e);
    endtask
    task automatic t_move_or();
        run(op_mem_move_load, 11'h405, 8'hc3, 8'h3c, 6'h2a, 8'hc3, 8'hc3, 6'h2a);
        run(op_mem_move_load, 11'h406, 8'h00, 8'h3c, 6'h00, 8'h00, 8'h00, 6'h00);
        run(op_mem_move_store, 11'h407, 8'hc3, 8'h3c, 6'h15, 8'h3c, 8'h3c, 6'h15);
        run(op_or_to_working, 11'h408, 8'h00, 8'h00, 6'h3e, 8'h00, 8'h00, 6'h3f);
        run(op_or_into_mem, 11'h409, 8'h18, 8'h81, 6'h3f, 8'h99, 8'h81, 6'h3e);
    endtask
    task automatic t_rotate();
        run(op_rotate_left_mem, 11'h10, 8'h96, 8'h11, 6'h3f, 8'h2d, 8'h11, 6'h3f);
        run(op_rotate_left_to_working, 11'h11, 8'h96, 8'h11, 6'h3f, 8'h96, 8'h2d, 6'h3f);
        run(op_rotate_right_mem, 11'h12, 8'h96, 8'h11, 6'h3f, 8'h4b, 8'h11, 6'h3f);
        run(op_rotate_right_to_working, 11'h13, 8'h96, 8'h11, 6'h3f, 8'h96, 8'h4b, 6'h3f);
        run(op_rotate_left_thru_carry_mem, 11'h14, 8'h96, 8'h11, 6'h3d, 8'h2c, 8'h11, 6'h3f);
        run(op_rotate_left_thru_carry_to_working, 11'h15, 8'h16, 8'h11, 6'h02, 8'h16, 8'h2d,
            6'h00);
        run(op_rotate_right_thru_carry_mem, 11'h16, 8'h96, 8'h11, 6'h3f, 8'hcb, 8'h11, 6'h3d);
        run(op_rotate_right_thru_carry_to_working, 11'h17, 8'h97, 8'h11, 6'h00, 8'h97, 8'h4b,
            6'h02);
    endtask
    task automatic t_bcd();
        run(op_bcd_adjust_to_mem, 11'h20, 8'h55, 8'h99, 6'h38, 8'h99, 8'h99, 6'h38);
        run(op_bcd_adjust_to_mem, 11'h21, 8'h55, 8'h0a, 6'h00, 8'h10, 8'h0a, 6'h00);
        run(op_bcd_adjust_to_mem, 11'h22, 8'h55, 8'h12, 6'h3d, 8'h18, 8'h12, 6'h3d);
        run(op_bcd_adjust_to_mem, 11'h23, 8'h55, 8'ha0, 6'h00, 8'h00, 8'ha0, 6'h02);
        run(op_bcd_adjust_to_mem, 11'h24, 8'h55, 8'h15, 6'h02, 8'h75, 8'h15, 6'h02);
        run(op_bcd_adjust_to_mem, 11'h25, 8'h55, 8'hab, 6'h00, 8'h11, 8'hab, 6'h02);
    endtask
    task automatic t_sbc();
        run(op_subtract_borrow_to_working, 11'h30, 8'h03, 8'h05, 6'h02, 8'h03, 8'h02, 6'h06);
        run(op_subtract_borrow_to_working, 11'h31, 8'h05, 8'h05, 6'h20, 8'h05, 8'hff, 6'h10);
        run(op_subtract_borrow_into_mem, 11'h32, 8'h04, 8'h05, 6'h20, 8'h00, 8'h05, 6'h27);
        run(op_subtract_borrow_into_mem, 11'h33, 8'h01, 8'h80, 6'h02, 8'h7f, 8'h80, 6'h1a);
    endtask
    // Back-to-back ops on one byte: each must see the previous write
    task automatic t_chain();
        logic [7:0] got;
        run(op_mem_increment, 11'h2aa, 8'hfe, 8'h00, 6'h00, 8'hff, 8'h00, 6'h00);
        do_op(op_mem_increment, 11'h2aa);
        do_op(op_increment_to_working, 11'h2aa);
        chk(working_register, 8'h01);
        mem_rd(11'h2aa, got);
        chk(got, 8'h00);
    endtask
    // Codes beyond the table: completion flagged, nothing altered
    task automatic t_illegal();
        run(op_t'(5'h15), 11'h123, 8'h5a, 8'h33, 6'h2b, 8'h5a, 8'h33, 6'h2b);
        run(op_t'(5'h1f), 11'h124, 8'ha5, 8'hcc, 6'h14, 8'ha5, 8'hcc, 6'h14);
    endtask
    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cut a hung run short; the sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_reset_state();
        t_invert_step();
        t_move_or();
        t_rotate();
        t_bcd();
        t_sbc();
        t_chain();
        t_illegal();
        conclude();
    end
endmodule
bind extended_memory_operand_alu ext_alu_assertions i_ext_alu_assertions (.sys_clk(sys_clk),
    .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .op_done(op_done), .acc_load_en(acc_load_en), .flag_load_en(flag_load_en),
    .working_register(working_register), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag),
    .signed_range_exceeded_flag(signed_range_exceeded_flag),
    .signed_result_flag(signed_result_flag), .chained_zero_flag(chained_zero_flag),
    .host_rd_en(host_rd_en), .host_rd_valid(host_rd_valid));
